// *** asp_core.v ***
`include "asp_map.vh"

// Function
// [RQ1] one serial output pin drives bits, one serial input pin samples bits
// [RQ2] character length selectable as seven or eight bits, both directions
// [RQ3] bit rate comes from a five-bit divider baud generator
// [RQ4] transmit and receive run independently of each other
// [RQ5] four base clock sources selectable for the baud logic
// [RQ6] data always shifted least significant bit first
// [RQ7] operation stop mode: power enable low, no communication
// [RQ8] clock supply stopped: all registers and the output pin hold
// [RQ9] software clears power, receive and transmit enables after restart
// [RQ10] software sets power enable before transmit or receive enable
// [RQ11] enables synchronised to base clock; software waits two base clocks
// [RQ12] software waits before loading transmit data after enabling
// [RQ13] receive shifter deserialises, completed character moves to buffer
// [RQ14] seven-bit characters land in bits 0 to 6, bit 7 zero
// [RQ15] on overrun the new character is not moved into the buffer
// [RQ16] receive buffer readable as a byte, writes ignored
// [RQ17] receive buffer all ones on reset or power enable cleared
// [RQ18] byte write to transmit shift register starts transmission
// [RQ19] transmit shift register is write-only; reads do not show data
// [RQ20] transmit shift register all ones on reset, power or enable clear
// [RQ21] transmit-done event after each character; software waits for it
// [RQ22] power clear stops clock, resets circuit, holds input high
// [RQ23] clearing an enable resets that direction's circuit
// [RQ24] two-bit parity select: none, zero, odd, even
// [RQ25] one or two transmit stop bits; receive checks one stop bit
// [RQ26] frame: low start, data lsb first, parity, high stops, idle high
module asp_core (
  input  wire       core_clk_i,
  input  wire       sys_rst_i,
  input  wire       clk_en_i,
  input  wire [7:0] reg_addr_i,
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  input  wire [7:0] reg_wdata_i,
  output wire [7:0] reg_rdata_o,
  output wire       txs_ready_o,
  input  wire       serial_in_pin_i,
  output wire       serial_out_pin_o,
  output wire       transmit_done_interrupt_o,
  output wire       receive_done_o,
  output wire       receive_error_o
);
  localparam ST_IDLE = 5'h01;
  localparam ST_STRT = 5'h02;
  localparam ST_DATA = 5'h04;
  localparam ST_PAR  = 5'h08;
  localparam ST_STOP = 5'h10;

  // base clock tick for divide-by 2, 4, 8 or 16 of the core clock
  function base_hit;
    input [3:0] cnt;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    base_hit = cnt[0];
        2'h1:    base_hit = &cnt[1:0];
        2'h2:    base_hit = &cnt[2:0];
        default: base_hit = &cnt;
      endcase
    end
  endfunction

  // parity bit to send, or expected, for the data held
  function par_bit;
    input [7:0] data;
    input [1:0] sel;
    begin
      case (sel)
        `ASP_PAR_ODD:  par_bit = ~^data;
        `ASP_PAR_EVEN: par_bit = ^data;
        default:       par_bit = 1'b0;
      endcase
    end
  endfunction

  reg  [7:0] mode_q;
  reg  [7:0] baud_q;
  reg  [2:0] err_q;
  reg  [7:0] rxbuf_q;
  reg        rxbuf_full_q;
  reg  [7:0] rdata_q;
  reg  [3:0] pre_q;
  reg  [1:0] txe_s_q;
  reg  [1:0] rxe_s_q;
  reg  [4:0] tx_state_q;
  reg  [7:0] tx_shift_q;
  reg  [4:0] tx_div_q;
  reg        tx_ph_q;
  reg  [2:0] tx_cnt_q;
  reg        tx_par_q;
  reg        txd_q;
  reg        tx_done_q;
  reg  [4:0] rx_state_q;
  reg  [7:0] rx_shift_q;
  reg  [4:0] rx_div_q;
  reg        rx_ph_q;
  reg  [2:0] rx_cnt_q;
  reg        rx_par_q;
  reg        rx_done_q;
  reg        rx_err_q;

  wire       power;
  wire       base_tick;
  wire [4:0] div_k;
  wire [1:0] psel;
  wire       len8;
  wire [2:0] last_bit;
  wire       rxd;
  wire       tx_run;
  wire       rx_run;
  wire       tx_half;
  wire       tx_bit_end;
  wire       rx_half;
  wire       rx_sample;
  wire       wr_txs;
  wire       rd_rxb;
  wire       rd_err;
  wire       fifo_ready;
  wire       fifo_valid;
  wire [7:0] fifo_data;
  wire       fifo_pop;
  wire [7:0] rx_char;
  wire       rx_perr;

  assign power     = mode_q[`ASP_MODE_POWER];
  assign psel      = mode_q[`ASP_MODE_PS_HI:`ASP_MODE_PS_LO];
  assign len8      = mode_q[`ASP_MODE_CL];                         // [RQ2]
  assign last_bit  = len8 ? 3'h7 : 3'h6;
  assign div_k     = baud_q[`ASP_BAUD_DIV_HI:`ASP_BAUD_DIV_LO];
  assign base_tick = power &
                     base_hit(pre_q, baud_q[`ASP_BAUD_TPS_HI:
                                            `ASP_BAUD_TPS_LO]);    // [RQ5]
  assign rxd       = power ? serial_in_pin_i : 1'b1;               // [RQ22]
  assign tx_run    = power & mode_q[`ASP_MODE_TXE] & txe_s_q[1];   // [RQ4]
  assign rx_run    = power & mode_q[`ASP_MODE_RXE] & rxe_s_q[1];
  // half-bit ticks: a divider of zero is treated as one
  assign tx_half    = base_tick & (tx_div_q + 5'h01 >= div_k);     // [RQ3]
  assign tx_bit_end = tx_half & tx_ph_q;
  assign rx_half    = base_tick & (rx_div_q + 5'h01 >= div_k);
  assign rx_sample  = rx_half & rx_ph_q;
  assign wr_txs    = reg_wr_i & (reg_addr_i == `ASP_ADDR_TXSHIFT);
  assign rd_rxb    = reg_rd_i & (reg_addr_i == `ASP_ADDR_RXBUF);
  assign rd_err    = reg_rd_i & (reg_addr_i == `ASP_ADDR_ERR);
  assign fifo_pop  = tx_run & (tx_state_q == ST_IDLE);
  assign rx_char   = len8 ? rx_shift_q : {1'b0, rx_shift_q[7:1]};  // [RQ14]
  assign rx_perr   = psel[1] & (rx_par_q != par_bit(rx_char, psel));

  assign reg_rdata_o               = rdata_q;
  assign txs_ready_o               = fifo_ready;
  assign serial_out_pin_o          = txd_q;                        // [RQ1]
  assign transmit_done_interrupt_o = tx_done_q;
  assign receive_done_o            = rx_done_q;
  assign receive_error_o           = rx_err_q;

  // absorbs a write landing while the shifter still finishes a frame
  asp_fifo2 #(
    .WIDTH (8)
  ) u_txbuf (
    .core_clk_i  (core_clk_i),
    .sys_rst_i   (sys_rst_i),
    .clk_en_i    (clk_en_i),
    .clr_i       (~tx_run),
    .in_valid_i  (wr_txs),
    .in_ready_o  (fifo_ready),
    .in_data_i   (reg_wdata_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_data)
  );

  // register port; clk_en_i low freezes every flop here [RQ8]
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      mode_q  <= `ASP_MODE_RST;
      baud_q  <= `ASP_BAUD_RST;
      rdata_q <= `ASP_ZERO;
      pre_q   <= 4'h0;
      txe_s_q <= 2'h0;
      rxe_s_q <= 2'h0;
    end else if (clk_en_i) begin
      if (reg_wr_i && reg_addr_i == `ASP_ADDR_MODE)
        mode_q <= reg_wdata_i | `ASP_MODE_RST;
      if (reg_wr_i && reg_addr_i == `ASP_ADDR_BAUD)
        baud_q <= reg_wdata_i & 8'hDF;
      pre_q <= power ? pre_q + 4'h1 : 4'h0;                        // [RQ7]
      // enables pass two base clock stages; a clear acts at once
      if (!mode_q[`ASP_MODE_TXE] || !power)
        txe_s_q <= 2'h0;                                           // [RQ23]
      else if (base_tick)
        txe_s_q <= {txe_s_q[0], 1'b1};                             // [RQ11]
      if (!mode_q[`ASP_MODE_RXE] || !power)
        rxe_s_q <= 2'h0;
      else if (base_tick)
        rxe_s_q <= {rxe_s_q[0], 1'b1};
      if (reg_rd_i) begin
        case (reg_addr_i)
          `ASP_ADDR_MODE:    rdata_q <= mode_q;
          `ASP_ADDR_BAUD:    rdata_q <= baud_q;
          `ASP_ADDR_RXBUF:   rdata_q <= rxbuf_q;                   // [RQ16]
          `ASP_ADDR_ERR:     rdata_q <= {5'h00, err_q};
          `ASP_ADDR_TXSHIFT: rdata_q <= `ASP_ONES;                 // [RQ19]
          default:           rdata_q <= `ASP_ZERO;
        endcase
      end
    end
  end

  // transmitter
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tx_state_q <= ST_IDLE;
      tx_shift_q <= `ASP_ONES;
      tx_div_q   <= 5'h00;
      tx_ph_q    <= 1'b0;
      tx_cnt_q   <= 3'h0;
      tx_par_q   <= 1'b0;
      txd_q      <= 1'b1;
      tx_done_q  <= 1'b0;
    end else if (clk_en_i) begin
      tx_done_q <= 1'b0;
      if (!tx_run) begin
        tx_state_q <= ST_IDLE;
        tx_shift_q <= `ASP_ONES;                                   // [RQ20]
        tx_div_q   <= 5'h00;
        tx_ph_q    <= 1'b0;
        txd_q      <= 1'b1;
      end else begin
        if (tx_half) begin
          tx_div_q <= 5'h00;
          tx_ph_q  <= ~tx_ph_q;
        end else if (base_tick) begin
          tx_div_q <= tx_div_q + 5'h01;
        end
        case (tx_state_q)
          ST_IDLE: begin
            txd_q <= 1'b1;
            if (fifo_valid) begin
              tx_shift_q <= fifo_data;                             // [RQ18]
              tx_par_q   <= par_bit(len8 ? fifo_data :
                                    {1'b0, fifo_data[6:0]}, psel);
              txd_q      <= 1'b0;                                  // [RQ26]
              tx_div_q   <= 5'h00;
              tx_ph_q    <= 1'b0;
              tx_state_q <= ST_STRT;
            end
          end
          ST_STRT: begin
            if (tx_bit_end) begin
              txd_q      <= tx_shift_q[0];                         // [RQ6]
              tx_cnt_q   <= 3'h0;
              tx_state_q <= ST_DATA;
            end
          end
          ST_DATA: begin
            if (tx_bit_end) begin
              tx_shift_q <= {1'b1, tx_shift_q[7:1]};
              tx_cnt_q   <= tx_cnt_q + 3'h1;
              if (tx_cnt_q != last_bit) begin
                txd_q <= tx_shift_q[1];
              end else if (psel != `ASP_PAR_NONE) begin
                txd_q      <= tx_par_q;                            // [RQ24]
                tx_state_q <= ST_PAR;
              end else begin
                txd_q      <= 1'b1;
                tx_cnt_q   <= 3'h0;
                tx_state_q <= ST_STOP;
              end
            end
          end
          ST_PAR: begin
            if (tx_bit_end) begin
              txd_q      <= 1'b1;
              tx_cnt_q   <= 3'h0;
              tx_state_q <= ST_STOP;
            end
          end
          ST_STOP: begin
            if (tx_bit_end) begin
              tx_cnt_q <= tx_cnt_q + 3'h1;
              if (tx_cnt_q[0] == mode_q[`ASP_MODE_SL]) begin       // [RQ25]
                tx_done_q  <= 1'b1;                                // [RQ21]
                tx_state_q <= ST_IDLE;
              end
            end
          end
          default: tx_state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // receiver; buffer and status reset on power clear; a receive enable clear also clears the status and the full flag
  always @(posedge core_clk_i) begin
    if (sys_rst_i || (clk_en_i && !power)) begin
      rx_state_q   <= ST_IDLE;
      rx_shift_q   <= 8'h00;
      rx_div_q     <= 5'h00;
      rx_ph_q      <= 1'b0;
      rx_cnt_q     <= 3'h0;
      rx_par_q     <= 1'b0;
      rx_done_q    <= 1'b0;
      rx_err_q     <= 1'b0;
      rxbuf_q      <= `ASP_ONES;                                   // [RQ17]
      rxbuf_full_q <= 1'b0;
      err_q        <= `ASP_ERR_RST;                                // [RQ22]
    end else if (clk_en_i) begin
      rx_done_q <= 1'b0;
      rx_err_q  <= 1'b0;
      if (rd_rxb)
        rxbuf_full_q <= 1'b0;
      if (rd_err)
        err_q <= `ASP_ERR_RST;
      if (!rx_run) begin
        rx_state_q <= ST_IDLE;                                     // [RQ23]
        err_q      <= `ASP_ERR_RST;
        // an unread character is dropped too, so a re-enable starts clean
        rxbuf_full_q <= 1'b0;
      end else begin
        if (rx_half) begin
          rx_div_q <= 5'h00;
          rx_ph_q  <= ~rx_ph_q;
        end else if (base_tick) begin
          rx_div_q <= rx_div_q + 5'h01;
        end
        case (rx_state_q)
          ST_IDLE: begin
            if (!rxd) begin
              rx_div_q   <= 5'h00;
              rx_ph_q    <= 1'b1;
              rx_state_q <= ST_STRT;
            end
          end
          ST_STRT: begin
            if (rx_sample) begin
              rx_cnt_q   <= 3'h0;
              rx_state_q <= rxd ? ST_IDLE : ST_DATA;
            end
          end
          ST_DATA: begin
            if (rx_sample) begin
              rx_shift_q <= {rxd, rx_shift_q[7:1]};                // [RQ13]
              rx_cnt_q   <= rx_cnt_q + 3'h1;
              if (rx_cnt_q == last_bit)
                rx_state_q <= (psel != `ASP_PAR_NONE) ? ST_PAR : ST_STOP;
            end
          end
          ST_PAR: begin
            if (rx_sample) begin
              rx_par_q   <= rxd;
              rx_state_q <= ST_STOP;
            end
          end
          ST_STOP: begin
            // one stop bit checked whatever the stop setting
            if (rx_sample) begin
              rx_state_q <= ST_IDLE;                               // [RQ25]
              rx_done_q  <= 1'b1;
              rx_err_q   <= ~rxd | rx_perr | rxbuf_full_q;
              // status sets win over a read-clear in the same cycle
              err_q <= (rd_err ? `ASP_ERR_RST : err_q) |
                       {rx_perr, ~rxd, rxbuf_full_q};              // [RQ24]
              if (!rxbuf_full_q) begin
                rxbuf_q      <= rx_char;
                rxbuf_full_q <= 1'b1;
              end                                                  // [RQ15]
            end
          end
          default: rx_state_q <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

// *** asp_map.vh ***
`ifndef ASP_MAP_VH
`define ASP_MAP_VH
// register addresses on the cpu register port
`define ASP_ADDR_MODE      8'h70
`define ASP_ADDR_BAUD      8'h71
`define ASP_ADDR_RXBUF     8'h72
`define ASP_ADDR_ERR       8'h73
`define ASP_ADDR_TXSHIFT   8'h74
// reset values
`define ASP_MODE_RST       8'h01
`define ASP_BAUD_RST       8'h1F
`define ASP_ERR_RST        3'h0
`define ASP_ONES           8'hFF
`define ASP_ZERO           8'h00
// serial_mode_control fields
`define ASP_MODE_POWER     7
`define ASP_MODE_TXE       6
`define ASP_MODE_RXE       5
`define ASP_MODE_PS_HI     4
`define ASP_MODE_PS_LO     3
`define ASP_MODE_CL        2
`define ASP_MODE_SL        1
`define ASP_MODE_FIXED     0
// baud_generator_control fields
`define ASP_BAUD_TPS_HI    7
`define ASP_BAUD_TPS_LO    6
`define ASP_BAUD_DIV_HI    4
`define ASP_BAUD_DIV_LO    0
// receive_error_status fields
`define ASP_ERR_PARITY     2
`define ASP_ERR_FRAME      1
`define ASP_ERR_OVERRUN    0
// parity selections
`define ASP_PAR_NONE       2'h0
`define ASP_PAR_ZERO       2'h1
`define ASP_PAR_ODD        2'h2
`define ASP_PAR_EVEN       2'h3
`endif

// *** asp_fifo2.v ***
module asp_fifo2 #(
  parameter WIDTH = 8
) (
  input  wire             core_clk_i,
  input  wire             sys_rst_i,
  input  wire             clk_en_i,
  input  wire             clr_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  // head entry always sits in slot 0, so read data come from a register
  reg  [WIDTH-1:0] slot0_q;
  reg  [WIDTH-1:0] slot1_q;
  reg  [1:0]       cnt_q;
  reg              ready_q;
  reg              valid_q;
  wire             push;
  wire             pop;
  wire [1:0]       cnt_d;
  wire [1:0]       wslot;

  assign push        = in_valid_i & ready_q;
  assign pop         = valid_q & out_ready_i;
  assign cnt_d       = cnt_q + {1'b0, push} - {1'b0, pop};
  assign wslot       = cnt_q - {1'b0, pop};
  assign in_ready_o  = ready_q;
  assign out_valid_o = valid_q;
  assign out_data_o  = slot0_q;

  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      slot0_q <= {WIDTH{1'b0}};
      slot1_q <= {WIDTH{1'b0}};
      cnt_q   <= 2'h0;
      ready_q <= 1'b1;
      valid_q <= 1'b0;
    end else if (clk_en_i) begin
      if (clr_i) begin
        cnt_q   <= 2'h0;
        ready_q <= 1'b1;
        valid_q <= 1'b0;
      end else begin
        if (push && wslot == 2'h0)
          slot0_q <= in_data_i;
        else if (pop)
          slot0_q <= slot1_q;
        if (push && wslot == 2'h1)
          slot1_q <= in_data_i;
        cnt_q   <= cnt_d;
        ready_q <= (cnt_d != 2'h2);
        valid_q <= (cnt_d != 2'h0);
      end
    end
  end
endmodule

// *** asp_core_asserts.sv ***
`include "asp_map.vh"

module asp_core_asserts (
  input wire logic       core_clk_i,
  input wire logic       sys_rst_i,
  input wire logic       clk_en_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       txs_ready_o,
  input wire logic       serial_in_pin_i,
  input wire logic       serial_out_pin_o,
  input wire logic       transmit_done_interrupt_o,
  input wire logic       receive_done_o,
  input wire logic       receive_error_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // shadow of the mode register, rebuilt from accepted writes
  logic [7:0] mode_q;
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      mode_q <= `ASP_MODE_RST;
    end else if (clk_en_i && reg_wr_i && reg_addr_i == `ASP_ADDR_MODE) begin
      mode_q <= reg_wdata_i;
    end
  end

  sequence s_rd(a);
    clk_en_i && reg_rd_i && reg_addr_i == a;
  endsequence
  sequence s_pwr_off;
    clk_en_i && reg_wr_i && reg_addr_i == `ASP_ADDR_MODE && !reg_wdata_i[7];
  endsequence
  sequence s_txs_wr;
    clk_en_i && reg_wr_i && reg_addr_i == `ASP_ADDR_TXSHIFT && txs_ready_o;
  endsequence

  AST_RST_IDLE: assert property ($fell(sys_rst_i) |->
    serial_out_pin_o && txs_ready_o && reg_rdata_o == 8'h00)
    else $error("outputs not idle after reset");
  AST_HOLD: assert property (!clk_en_i |=>
    $stable(serial_out_pin_o) && $stable(reg_rdata_o))
    else $error("state moved while clock stopped");
  AST_TXS_READ: assert property (s_rd(`ASP_ADDR_TXSHIFT) |=>
    reg_rdata_o == 8'hFF)
    else $error("transmit shift read did not give all ones");
  AST_RXB_CLEAR: assert property (s_pwr_off ##2 s_rd(`ASP_ADDR_RXBUF) |=>
    reg_rdata_o == 8'hFF)
    else $error("receive buffer not all ones after power clear");
  AST_TX_START: assert property (s_txs_wr ##0 mode_q[7] && mode_q[6]
    |-> ##[1:300] !serial_out_pin_o)
    else $error("write to transmit shift started no frame");
  AST_START_LEN: assert property ($fell(serial_out_pin_o) |->
    (!serial_out_pin_o) [*6])
    else $error("low bit on the output too short");
  AST_DONE_HIGH: assert property (transmit_done_interrupt_o |->
    serial_out_pin_o)
    else $error("transmit done while line not at stop level");
  AST_ERR_PAIR: assert property (receive_error_o |-> receive_done_o)
    else $error("receive error without receive done");
  AST_RXDONE_PULSE: assert property (receive_done_o && clk_en_i |=>
    !receive_done_o)
    else $error("receive done longer than one cycle");
  AST_TXOFF_IDLE: assert property (!mode_q[6] |=> serial_out_pin_o)
    else $error("output not idle with transmit disabled");
endmodule

bind asp_core asp_core_asserts u_asp_core_asserts (
  .core_clk_i, .sys_rst_i, .clk_en_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
  .reg_wdata_i, .reg_rdata_o, .txs_ready_o, .serial_in_pin_i,
  .serial_out_pin_o, .transmit_done_interrupt_o, .receive_done_o,
  .receive_error_o
);

// *** asp_serial_peer.sv ***
module asp_serial_peer #(
  parameter int BIT = 8
) (
  input  wire logic       clk_i,
  input  wire logic       line_i,
  output logic            line_o,
  input  wire logic [1:0] par_i,
  input  wire logic       len8_i,
  input  wire logic       two_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] got_q[$];
  int         bad = 0;

  function automatic logic par_bit(input logic [7:0] d);
    return (par_i == 2'h1) ? 1'b0 : (par_i == 2'h2) ? ~^d : ^d;
  endfunction

  initial line_o = 1'b1;

  // samples the device's frames mid-bit, keeps {parity, data}
  always begin : rx
    logic [7:0] d;
    logic       p;
    @(negedge line_i);
    d = 8'h00;
    p = 1'b0;
    repeat (BIT / 2) @(posedge clk_i);
    if (line_i !== 1'b0) bad++;
    for (int i = 0; i < (len8_i ? 8 : 7); i++) begin
      repeat (BIT) @(posedge clk_i);
      d[i] = line_i;
    end
    if (par_i != 2'h0) begin
      repeat (BIT) @(posedge clk_i);
      p = line_i;
    end
    repeat (BIT) @(posedge clk_i);
    if (line_i !== 1'b1) bad++;
    if (two_i) begin
      repeat (BIT) @(posedge clk_i);
      if (line_i !== 1'b1) bad++;
    end
    got_q.push_back({p, d});
  end

  // one frame towards the device, one stop bit; flip spoils the parity
  task automatic send(input logic [7:0] d, input logic flip);
    logic [7:0] m;
    m = len8_i ? d : {1'b0, d[6:0]};
    @(posedge clk_i) line_o <= 1'b0;
    for (int i = 0; i < (len8_i ? 8 : 7); i++) begin
      repeat (BIT) @(posedge clk_i);
      line_o <= m[i];
    end
    if (par_i != 2'h0) begin
      repeat (BIT) @(posedge clk_i);
      line_o <= par_bit(m) ^ flip;
    end
    repeat (BIT) @(posedge clk_i);
    line_o <= 1'b1;
    repeat (BIT) @(posedge clk_i);
  endtask
endmodule

// *** tb_top.sv ***
`include "asp_map.vh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       core_clk_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic       clk_en_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic       reg_wr_i = 1'b0;
  logic       reg_rd_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic       txs_ready_o, serial_in_pin_i, serial_out_pin_o;
  logic       transmit_done_interrupt_o, receive_done_o, receive_error_o;
  logic [1:0] par = 2'h0;
  logic       len8 = 1'b1;
  logic       two = 1'b0;
  logic [31:0] seed = 32'h8E75;
  logic [8:0] exp_q[$];
  int         fails = 0, tests_run = 0, ndone = 0, nerr = 0, cyc = 0, nrx = 0;

  asp_core u_asp_core (
    .core_clk_i, .sys_rst_i, .clk_en_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
    .reg_wdata_i, .reg_rdata_o, .txs_ready_o, .serial_in_pin_i,
    .serial_out_pin_o, .transmit_done_interrupt_o, .receive_done_o,
    .receive_error_o
  );
  // bit time: base clock core/2, divider 2 -> 8 core cycles
  asp_serial_peer #(.BIT(8)) u_asp_serial_peer (
    .clk_i(core_clk_i), .line_i(serial_out_pin_o), .line_o(serial_in_pin_i),
    .par_i(par), .len8_i(len8), .two_i(two)
  );

  initial begin
    forever #50 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    cyc++;
    if (transmit_done_interrupt_o === 1'b1 && clk_en_i) ndone++;
    if (receive_error_o === 1'b1 && clk_en_i) nerr++;
    if (receive_done_o === 1'b1 && clk_en_i) nrx++;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic chk(input string what, input logic [8:0] seen,
                     input logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // a write to the transmit shift is only kept while the buffer has room
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] m;
    @(negedge core_clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    m = len8 ? d : {1'b0, d[6:0]};
    if (a == `ASP_ADDR_TXSHIFT && txs_ready_o === 1'b1 && clk_en_i)
      exp_q.push_back({(par[1] ? (par[0] ? ^m : ~^m) : 1'b0), m});
    @(negedge core_clk_i);
    reg_wr_i = 1'b0;
  endtask

  task automatic rchk(input string what, input logic [7:0] a,
                      input logic [7:0] e);
    @(negedge core_clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge core_clk_i);
    reg_rd_i = 1'b0;
    chk(what, {1'b0, reg_rdata_o}, {1'b0, e});
  endtask

  // power on with enables off first, then both directions on
  task automatic cfg(input logic [1:0] p, input logic l8, input logic t2);
    par = p;
    len8 = l8;
    two = t2;
    wr(`ASP_ADDR_MODE, {3'b100, p, l8, t2, 1'b1});
    repeat (8) @(negedge core_clk_i);
    wr(`ASP_ADDR_MODE, {3'b111, p, l8, t2, 1'b1});
    repeat (8) @(negedge core_clk_i);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin : main
    logic [7:0] d, e;
    int         n;
    repeat (5) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    rchk("mode", `ASP_ADDR_MODE, `ASP_MODE_RST);
    rchk("rxbuf", `ASP_ADDR_RXBUF, `ASP_ONES);
    rchk("status", `ASP_ADDR_ERR, 8'h00);
    rchk("txshift", `ASP_ADDR_TXSHIFT, `ASP_ONES);
    wr(`ASP_ADDR_BAUD, 8'hFF);
    rchk("baud", `ASP_ADDR_BAUD, 8'hDF);
    wr(`ASP_ADDR_BAUD, 8'h02);
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      cfg(m[1:0], m[0], m[1]);
      n = ndone;
      repeat (4) wr(`ASP_ADDR_TXSHIFT, rnd());
      chk("accepted", 9'(exp_q.size()), 9'd3);
      for (int i = 0; i < 2000 && u_asp_serial_peer.got_q.size() < 3; i++)
        @(negedge core_clk_i);
      repeat (16) @(negedge core_clk_i);
      while (exp_q.size() > 0)
        chk("frame", u_asp_serial_peer.got_q.pop_front(), exp_q.pop_front());
      chk("done pulses", 9'(ndone - n), 9'd3);
    end
    chk("framing", 9'(u_asp_serial_peer.bad), 9'd0);
    $display("test transmit done");
    cfg(`ASP_PAR_EVEN, 1'b1, 1'b0);
    d = rnd();
    u_asp_serial_peer.send(d, 1'b0);
    rchk("rx byte", `ASP_ADDR_RXBUF, d);
    rchk("rx status", `ASP_ADDR_ERR, 8'h00);
    e = rnd();
    u_asp_serial_peer.send(e, 1'b0);
    u_asp_serial_peer.send(rnd(), 1'b0);
    rchk("overrun keeps", `ASP_ADDR_RXBUF, e);
    rchk("overrun flag", `ASP_ADDR_ERR, 8'h01);
    rchk("status cleared", `ASP_ADDR_ERR, 8'h00);
    wr(`ASP_ADDR_RXBUF, ~e);
    rchk("rxbuf write", `ASP_ADDR_RXBUF, e);
    n = nerr;
    u_asp_serial_peer.send(rnd(), 1'b1);
    rchk("parity flag", `ASP_ADDR_ERR, 8'h04);
    chk("error pulse", 9'(nerr - n), 9'd1);
    cfg(`ASP_PAR_ZERO, 1'b0, 1'b1);
    d = rnd() | 8'h80;
    u_asp_serial_peer.send(d, 1'b1);
    rchk("seven bit", `ASP_ADDR_RXBUF, {1'b0, d[6:0]});
    rchk("zero parity", `ASP_ADDR_ERR, 8'h00);
    chk("rx done pulses", 9'(nrx), 9'd5);
    $display("test receive done");
    @(negedge core_clk_i);
    clk_en_i = 1'b0;
    wr(`ASP_ADDR_MODE, 8'h01);
    repeat (4) @(negedge core_clk_i);
    clk_en_i = 1'b1;
    rchk("frozen", `ASP_ADDR_RXBUF, {1'b0, d[6:0]});
    wr(`ASP_ADDR_MODE, 8'h01);
    rchk("power off rxbuf", `ASP_ADDR_RXBUF, `ASP_ONES);
    rchk("power off status", `ASP_ADDR_ERR, 8'h00);
    $display("test stop and power off done");
    test_done();
  end
endmodule
